// *** rtl/oapl_pkg.sv ***
// Constants and types for the OR and pointer-load decode block.
// Assumes a four-phase instruction cycle on mclk and 16-bit instruction words.
`default_nettype none
package oapl_pkg;
	// Instruction cycle phases Q1..Q4, one mclk each
	localparam logic [1:0] PHASE_Q1 = 2'h0;
	localparam logic [1:0] PHASE_Q2 = 2'h1;
	localparam logic [1:0] PHASE_Q3 = 2'h2;
	localparam logic [1:0] PHASE_Q4 = 2'h3;
	localparam logic [1:0] PHASE_RESET = 2'h0;
	// Opcode fields
	localparam logic [7:0] OPC_OR_LITERAL = 8'h09;
	localparam logic [5:0] OPC_OR_FILE = 6'h04;
	localparam logic [9:0] OPC_LOAD_PTR_FIRST = 10'h3b8;
	localparam logic [7:0] OPC_LOAD_PTR_SECOND = 8'hf0;
	// Field positions
	localparam int DEST_BIT = 9;
	localparam int BANK_BIT = 8;
	localparam int PTR_IDX_LSB = 4;
	// Address spaces
	localparam int BANK_W = 4;
	localparam int FILE_ADDR_W = 12;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [7:0] INDEXED_LAST = 8'h5f;
	localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hf;
	localparam logic [3:0] ACCESS_LOW_PAGE = 4'h0;
	// Pointer registers
	localparam int PTR_COUNT = 3;
	localparam int PTR_W = 12;
	localparam logic [1:0] PTR_INDEXED = 2'h2;
	// Reset values
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [11:0] PTR_RESET = 12'h000;
	localparam logic [11:0] FILE_ADDR_RESET = 12'h000;
	localparam logic [7:0] DATA_RESET = 8'h00;
	typedef enum logic [1:0] {
		ST_SINGLE = 2'b00,
		ST_SECOND = 2'b01
	} oapl_state_type;
	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_OR_LIT = 2'b01,
		OP_OR_FILE = 2'b11,
		OP_LOAD_PTR = 2'b10
	} oapl_op_type;
endpackage
`default_nettype wire

// *** rtl/oapl_or_unit.sv ***
// Byte OR with negative and zero results.
// Purely combinational; the caller registers everything it uses.
`default_nettype none
module oapl_or_unit (
	// Operands
	input wire logic [7:0] opA,
	input wire logic [7:0] opB,
	// Result
	output logic [7:0] result,
	output logic negative,
	output logic zero
);
	always_comb begin
		result = opA | opB;
		negative = result[7];
		zero = (result == 8'h00);
	end
endmodule
`default_nettype wire

// *** rtl/or_and_pointer_load_decode.sv ***
// Decode and execute for literal OR, OR with file register and pointer load.
// Assumes program memory presents a word at Q1 and data memory answers a
// read in the same mclk that fileRd is high, with fileRdData sampled at the end of Q3.
`default_nettype none
// Behaviour
// - The literal OR ors the accumulator with the 8-bit literal into the accumulator in one cycle.
// - The file OR ors the accumulator with the addressed file register in one single-word cycle.
// - Destination bit 0 sends the result to the accumulator and 1 writes it back to the file.
// - Bank bit 0 selects the access bank and 1 selects the bank given by bankSelect.
// - With bank bit 0, extended set on and address up to 5Fh, the operand is pointer 2 plus offset.
// - The pointer load writes a 12-bit literal into pointer 0..2 over two words, high part first.
module or_and_pointer_load_decode (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clkEn,
	// Instruction word from program memory
	input wire logic [15:0] instrWord,
	input wire logic instrValid,
	output logic [1:0] qPhase,
	output logic instrTaken,
	output logic instrOther,
	// Core context
	input wire logic extEnable,
	input wire logic [oapl_pkg::BANK_W-1:0] bankSelect,
	// Data memory
	output logic fileRd,
	output logic fileWr,
	output logic [oapl_pkg::FILE_ADDR_W-1:0] fileAddr,
	output logic [7:0] fileWrData,
	input wire logic [7:0] fileRdData,
	// Architectural state
	output logic [7:0] acc,
	output logic flagNeg,
	output logic flagZero,
	output logic [oapl_pkg::PTR_COUNT-1:0][oapl_pkg::PTR_W-1:0] pointerReg
);
	logic rstSync1, rstSync2;
	oapl_pkg::oapl_state_type state, next_state;
	oapl_pkg::oapl_op_type op, next_op;
	logic [1:0] next_qPhase;
	logic next_instrTaken, next_instrOther, next_fileRd, next_fileWr;
	logic [oapl_pkg::FILE_ADDR_W-1:0] next_fileAddr;
	logic [7:0] next_fileWrData, next_acc;
	logic next_flagNeg, next_flagZero;
	logic [oapl_pkg::PTR_COUNT-1:0][oapl_pkg::PTR_W-1:0] next_pointerReg;
	logic [7:0] lit, next_lit, fileOff, next_fileOff, opResult, next_opResult;
	logic destFile, next_destFile, bankBit, next_bankBit;
	logic resNeg, next_resNeg, resZero, next_resZero;
	logic [1:0] ptrIdx, next_ptrIdx;
	logic [7:0] orOut, orOperand;
	logic orNeg, orZero;

	// Reset is released through two stages so every flop leaves reset together
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rstSync1 <= 1'b0;
			rstSync2 <= 1'b0;
		end else begin
			rstSync1 <= 1'b1;
			rstSync2 <= rstSync1;
		end
	end

	assign orOperand = (op == oapl_pkg::OP_OR_FILE) ? fileRdData : lit;

	oapl_or_unit uOr (
		.opA(acc),
		.opB(orOperand),
		.result(orOut),
		.negative(orNeg),
		.zero(orZero)
	);

	always_comb begin
		next_state = state;
		next_op = op;
		next_qPhase = qPhase + 2'h1;
		next_instrTaken = 1'b0;
		next_instrOther = 1'b0;
		next_fileRd = 1'b0;
		next_fileWr = 1'b0;
		next_fileAddr = fileAddr;
		next_fileWrData = fileWrData;
		next_acc = acc;
		next_flagNeg = flagNeg;
		next_flagZero = flagZero;
		next_pointerReg = pointerReg;
		next_lit = lit;
		next_fileOff = fileOff;
		next_destFile = destFile;
		next_bankBit = bankBit;
		next_ptrIdx = ptrIdx;
		next_opResult = opResult;
		next_resNeg = resNeg;
		next_resZero = resZero;
		case (qPhase)
			oapl_pkg::PHASE_Q1: begin
				next_op = oapl_pkg::OP_NONE;
				if (instrValid) begin
					next_instrTaken = 1'b1;
					if (state == oapl_pkg::ST_SECOND) begin
						if (instrWord[15:8] == oapl_pkg::OPC_LOAD_PTR_SECOND) begin
							next_op = oapl_pkg::OP_LOAD_PTR;
							next_lit = instrWord[7:0];
						end else begin
							// A broken pair is handed on and the pointer keeps its new high part
							next_instrOther = 1'b1;
							next_state = oapl_pkg::ST_SINGLE;
						end
					end else if (instrWord[15:8] == oapl_pkg::OPC_OR_LITERAL) begin
						next_op = oapl_pkg::OP_OR_LIT;
						next_lit = instrWord[7:0];
					end else if (instrWord[15:10] == oapl_pkg::OPC_OR_FILE) begin
						next_op = oapl_pkg::OP_OR_FILE;
						next_destFile = instrWord[oapl_pkg::DEST_BIT];
						next_bankBit = instrWord[oapl_pkg::BANK_BIT];
						next_fileOff = instrWord[7:0];
					end else if (instrWord[15:6] == oapl_pkg::OPC_LOAD_PTR_FIRST &&
						instrWord[5:4] < 2'(oapl_pkg::PTR_COUNT)) begin
						next_op = oapl_pkg::OP_LOAD_PTR;
						next_ptrIdx = instrWord[5:4];
						next_lit = {4'h0, instrWord[3:0]};
					end else begin
						next_instrOther = 1'b1;
					end
				end
			end
			oapl_pkg::PHASE_Q2: begin
				if (op == oapl_pkg::OP_OR_FILE) begin
					next_fileRd = 1'b1;
					if (bankBit) begin
						next_fileAddr = {bankSelect, fileOff};
					end else if (extEnable && fileOff <= oapl_pkg::INDEXED_LAST) begin
						next_fileAddr = pointerReg[oapl_pkg::PTR_INDEXED] +
							{4'h0, fileOff};
					end else if (fileOff < oapl_pkg::ACCESS_SPLIT) begin
						next_fileAddr = {oapl_pkg::ACCESS_LOW_PAGE, fileOff};
					end else begin
						next_fileAddr = {oapl_pkg::ACCESS_HIGH_PAGE, fileOff};
					end
				end
			end
			oapl_pkg::PHASE_Q3: begin
				if (op == oapl_pkg::OP_OR_LIT || op == oapl_pkg::OP_OR_FILE) begin
					next_opResult = orOut;
					next_resNeg = orNeg;
					next_resZero = orZero;
				end
			end
			default: begin
				case (op)
					oapl_pkg::OP_OR_LIT: begin
						next_acc = opResult;
						next_flagNeg = resNeg;
						next_flagZero = resZero;
					end
					oapl_pkg::OP_OR_FILE: begin
						if (destFile) begin
							next_fileWr = 1'b1;
							next_fileWrData = opResult;
						end else begin
							next_acc = opResult;
						end
						next_flagNeg = resNeg;
						next_flagZero = resZero;
					end
					oapl_pkg::OP_LOAD_PTR: begin
						// Flags are untouched on this path
						for (int i = 0; i < oapl_pkg::PTR_COUNT; i++) begin
							if (ptrIdx == 2'(i)) begin
								if (state == oapl_pkg::ST_SINGLE) begin
									next_pointerReg[i][11:8] = lit[3:0];
								end else begin
									next_pointerReg[i][7:0] = lit;
								end
							end
						end
						next_state = (state == oapl_pkg::ST_SINGLE) ?
							oapl_pkg::ST_SECOND : oapl_pkg::ST_SINGLE;
					end
					default: begin
						next_state = state;
					end
				endcase
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstSync2) begin
		if (!rstSync2) begin
			state <= oapl_pkg::ST_SINGLE;
			op <= oapl_pkg::OP_NONE;
			qPhase <= oapl_pkg::PHASE_RESET;
			instrTaken <= 1'b0;
			instrOther <= 1'b0;
			fileRd <= 1'b0;
			fileWr <= 1'b0;
			fileAddr <= oapl_pkg::FILE_ADDR_RESET;
			fileWrData <= oapl_pkg::DATA_RESET;
			acc <= oapl_pkg::ACC_RESET;
			flagNeg <= 1'b0;
			flagZero <= 1'b0;
			pointerReg <= {oapl_pkg::PTR_COUNT{oapl_pkg::PTR_RESET}};
			lit <= oapl_pkg::DATA_RESET;
			fileOff <= oapl_pkg::DATA_RESET;
			destFile <= 1'b1;
			bankBit <= 1'b0;
			ptrIdx <= 2'h0;
			opResult <= oapl_pkg::DATA_RESET;
			resNeg <= 1'b0;
			resZero <= 1'b0;
		end else if (clkEn) begin
			state <= next_state;
			op <= next_op;
			qPhase <= next_qPhase;
			instrTaken <= next_instrTaken;
			instrOther <= next_instrOther;
			fileRd <= next_fileRd;
			fileWr <= next_fileWr;
			fileAddr <= next_fileAddr;
			fileWrData <= next_fileWrData;
			acc <= next_acc;
			flagNeg <= next_flagNeg;
			flagZero <= next_flagZero;
			pointerReg <= next_pointerReg;
			lit <= next_lit;
			fileOff <= next_fileOff;
			destFile <= next_destFile;
			bankBit <= next_bankBit;
			ptrIdx <= next_ptrIdx;
			opResult <= next_opResult;
			resNeg <= next_resNeg;
			resZero <= next_resZero;
		end
	end

	// Checks count enabled cycles only, matching the frozen state
	default clocking cbEn @(posedge mclk iff clkEn);
	endclocking
	default disable iff (!rstSync2);

	sequence orLitTaken;
		qPhase == oapl_pkg::PHASE_Q1 && state == oapl_pkg::ST_SINGLE && instrValid &&
			instrWord[15:8] == oapl_pkg::OPC_OR_LITERAL;
	endsequence
	sequence orFileTaken;
		qPhase == oapl_pkg::PHASE_Q1 && state == oapl_pkg::ST_SINGLE && instrValid &&
			instrWord[15:10] == oapl_pkg::OPC_OR_FILE;
	endsequence
	sequence ptrFirstTaken;
		qPhase == oapl_pkg::PHASE_Q1 && state == oapl_pkg::ST_SINGLE && instrValid &&
			instrWord[15:4] == {oapl_pkg::OPC_LOAD_PTR_FIRST, 2'h2};
	endsequence
	sequence ptrSecondTaken;
		qPhase == oapl_pkg::PHASE_Q1 && state == oapl_pkg::ST_SECOND && instrValid &&
			instrWord[15:8] == oapl_pkg::OPC_LOAD_PTR_SECOND;
	endsequence

	orLit_acc_a: assert property (
		orLitTaken |-> ##4 (acc == ($past(acc, 4) | $past(instrWord[7:0], 4)) && !fileWr))
		else $error("literal OR did not land in the accumulator");
	orFile_read_a: assert property (
		orFileTaken |-> ##2 fileRd ##1 !fileRd)
		else $error("file OR did not read its operand once");
	dest_route_a: assert property (
		orFileTaken and instrWord[oapl_pkg::DEST_BIT] |-> ##4
			(fileWr && acc == $past(acc, 4) && fileWrData == ($past(acc, 4) | $past(fileRdData, 2))))
		else $error("file destination not written");
	dest_acc_a: assert property (
		orFileTaken and !instrWord[oapl_pkg::DEST_BIT] |-> ##4
			(!fileWr && acc == ($past(acc, 4) | $past(fileRdData, 2))))
		else $error("accumulator destination wrong");
	bank_select_a: assert property (
		qPhase == oapl_pkg::PHASE_Q2 && op == oapl_pkg::OP_OR_FILE && bankBit |=>
			fileAddr == {$past(bankSelect), $past(fileOff)})
		else $error("banked address wrong");
	indexed_mode_a: assert property (
		qPhase == oapl_pkg::PHASE_Q2 && op == oapl_pkg::OP_OR_FILE && !bankBit && extEnable &&
			fileOff <= oapl_pkg::INDEXED_LAST |=>
			fileAddr == $past(pointerReg[oapl_pkg::PTR_INDEXED]) + {4'h0, $past(fileOff)})
		else $error("indexed offset address wrong");
	ptr_high_a: assert property (
		ptrFirstTaken |-> ##4 (pointerReg[2][11:8] == $past(instrWord[3:0], 4) &&
			state == oapl_pkg::ST_SECOND))
		else $error("pointer high part not loaded first");
	// The second word may follow after idle Q1s, so the check starts from the second word
	ptr_pair_a: assert property (
		ptrSecondTaken and ptrIdx == oapl_pkg::PTR_INDEXED |-> ##4
			pointerReg[2] == {$past(pointerReg[2][11:8], 4), $past(instrWord[7:0], 4)})
		else $error("pointer load pair wrong");
	or_flags_a: assert property (
		qPhase == oapl_pkg::PHASE_Q4 &&
			(op == oapl_pkg::OP_OR_LIT || op == oapl_pkg::OP_OR_FILE) |=>
			flagZero == (opResult == 8'h00) && flagNeg == opResult[7])
		else $error("OR flags wrong");
	ptr_flags_a: assert property (
		op == oapl_pkg::OP_LOAD_PTR |=> $stable({flagNeg, flagZero}))
		else $error("pointer load changed flags");
endmodule
`default_nettype wire

// *** testbench/oapl_prog_mem.sv ***
// Program memory model: hands one queued word to the decoder in Q1.
// Assumes the bench queues a word only while none is pending.
`default_nettype none
module oapl_prog_mem (
	// Clock and phase
	input wire logic mclk,
	input wire logic [1:0] qPhase,
	// Bench request
	input wire logic req,
	input wire logic [15:0] reqWord,
	output logic pending,
	// Instruction port
	output logic [15:0] instrWord,
	output logic instrValid
);
	timeunit 1ns;
	timeprecision 1ps;
	assign instrValid = pending;
	initial begin
		pending = 1'b0;
		instrWord = 16'h0000;
	end
	always @(posedge mclk) begin
		if (req) begin
			pending <= 1'b1;
			instrWord <= reqWord;
		end else if (pending && qPhase == oapl_pkg::PHASE_Q1) begin
			// Released word lines flip so a stale value can never pass as valid
			pending <= 1'b0;
			instrWord <= ~instrWord;
		end
	end
endmodule
`default_nettype wire

// *** testbench/or_and_pointer_load_decode_tb_top.sv ***
// Self-checking bench for the OR and pointer-load decoder.
// Assumes the program memory model feeds words; data memory is the bench.
`default_nettype none
module or_and_pointer_load_decode_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic clkEn = 1'b1;
	logic req = 1'b0;
	logic [15:0] reqWord = 16'h0000;
	logic pending, instrValid, instrTaken, instrOther, fileRd, fileWr, flagNeg, flagZero;
	logic [15:0] instrWord;
	logic [1:0] qPhase;
	logic extEnable = 1'b0;
	logic [3:0] bankSelect = 4'h0;
	logic [7:0] rdValue = 8'h00;
	logic [7:0] fileRdData;
	logic [11:0] fileAddr, seenAddr;
	logic [7:0] fileWrData, acc, seenWr;
	logic [2:0][11:0] pointerReg;
	int fails = 0;
	int samplesChecked = 0;
	int wrCount = 0;
	int otherCount = 0;
	initial forever #4 mclk = ~mclk;
	oapl_prog_mem pm (.mclk(mclk), .qPhase(qPhase), .req(req), .reqWord(reqWord),
		.pending(pending), .instrWord(instrWord), .instrValid(instrValid));
	or_and_pointer_load_decode uut (.mclk(mclk), .rst_b(rst_b), .clkEn(clkEn),
		.instrWord(instrWord), .instrValid(instrValid), .qPhase(qPhase),
		.instrTaken(instrTaken), .instrOther(instrOther), .extEnable(extEnable),
		.bankSelect(bankSelect), .fileRd(fileRd), .fileWr(fileWr), .fileAddr(fileAddr),
		.fileWrData(fileWrData), .fileRdData(fileRdData), .acc(acc), .flagNeg(flagNeg),
		.flagZero(flagZero), .pointerReg(pointerReg));
	// Data memory side: outside a read the bus shows the inverse, so a mistimed sample fails
	assign fileRdData = fileRd ? rdValue : ~rdValue;
	always @(posedge mclk) begin
		if (fileRd)
			seenAddr <= fileAddr;
		if (fileWr) begin
			seenWr <= fileWrData;
			wrCount <= wrCount + 1;
		end
		if (instrOther)
			otherCount <= otherCount + 1;
	end
	task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
		samplesChecked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	task automatic finalReport();
		$display("checks %0d, mismatches %0d", samplesChecked, fails);
		if (fails == 0 && samplesChecked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// One word through the model with its level inputs, then the rest of its cycle;
	// stall drops clkEn for that many cycles just after the word is taken
	task automatic exec(input logic [15:0] w, input logic [3:0] bank, input logic [7:0] rd,
		input logic ext, input int stall);
		int n;
		@(posedge mclk);
		req <= 1'b1;
		reqWord <= w;
		bankSelect <= bank;
		rdValue <= rd;
		extEnable <= ext;
		@(posedge mclk);
		req <= 1'b0;
		n = 0;
		while (instrTaken !== 1'b1 && n < 8) begin
			@(posedge mclk);
			n++;
		end
		check("instrTaken", 12'h001, {11'h0, instrTaken});
		if (stall > 0) begin
			clkEn <= 1'b0;
			repeat (stall) @(posedge mclk);
			check("qPhase frozen", 12'h002, {10'h0, qPhase});
			clkEn <= 1'b1;
		end
		repeat (4) @(posedge mclk);
		#1;
	endtask
	task automatic orLitZero();
		exec(16'h0900, 4'h0, 8'h00, 1'b0, 0);
		check("acc", 12'h000, {4'h0, acc});
		check("zero", 12'h001, {11'h0, flagZero});
		check("neg", 12'h000, {11'h0, flagNeg});
	endtask
	task automatic orFileBanked();
		exec(16'h1344, 4'h3, 8'h13, 1'b0, 0);
		check("fileAddr", 12'h344, seenAddr);
		check("writes", 12'h001, wrCount[11:0]);
		check("fileWrData", 12'h013, {4'h0, seenWr});
		check("acc", 12'h000, {4'h0, acc});
		check("zero", 12'h000, {11'h0, flagZero});
	endtask
	task automatic orFileAccess();
		exec(16'h1060, 4'h0, 8'h91, 1'b1, 0);
		check("fileAddr", 12'hf60, seenAddr);
		check("acc", 12'h091, {4'h0, acc});
		check("writes", 12'h001, wrCount[11:0]);
		check("neg", 12'h001, {11'h0, flagNeg});
		exec(16'h0935, 4'h0, 8'h6e, 1'b1, 0);
		check("acc", 12'h0b5, {4'h0, acc});
	endtask
	task automatic loadPointer();
		exec(16'hee23, 4'h0, 8'h00, 1'b1, 0);
		check("pointer high", 12'h300, pointerReg[2]);
		exec(16'hf0ab, 4'h0, 8'h00, 1'b1, 0);
		check("pointer", 12'h3ab, pointerReg[2]);
		check("pointer0", 12'h000, pointerReg[0]);
		check("neg", 12'h001, {11'h0, flagNeg});
		check("zero", 12'h000, {11'h0, flagZero});
	endtask
	task automatic orFileIndexed();
		exec(16'h105f, 4'h0, 8'h00, 1'b1, 0);
		check("fileAddr", 12'h40a, seenAddr);
		check("acc", 12'h0b5, {4'h0, acc});
		exec(16'h105f, 4'h0, 8'h00, 1'b0, 0);
		check("fileAddr", 12'h05f, seenAddr);
	endtask
	// Index 3 is refused; a broken pair keeps its high part and hands the intruder on
	task automatic badPointer();
		exec(16'hee35, 4'h0, 8'h00, 1'b0, 0);
		check("others", 12'h001, otherCount[11:0]);
		check("pointer", 12'h3ab, pointerReg[2]);
		exec(16'hee17, 4'h0, 8'h00, 1'b0, 0);
		check("pointer1 high", 12'h700, pointerReg[1]);
		exec(16'h0901, 4'h0, 8'h00, 1'b0, 0);
		check("others", 12'h002, otherCount[11:0]);
		check("acc", 12'h0b5, {4'h0, acc});
		check("pointer1", 12'h700, pointerReg[1]);
	endtask
	// Mid-run reset, then a literal OR pair with the second one frozen by clkEn
	task automatic resetAndFreeze();
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		check("acc", 12'h000, {4'h0, acc});
		check("pointer", 12'h000, pointerReg[2]);
		check("neg", 12'h000, {11'h0, flagNeg});
		exec(16'h099a, 4'h0, 8'h00, 1'b0, 0);
		check("acc", 12'h09a, {4'h0, acc});
		exec(16'h0935, 4'h0, 8'h00, 1'b0, 3);
		check("acc", 12'h0bf, {4'h0, acc});
		check("neg", 12'h001, {11'h0, flagNeg});
		check("zero", 12'h000, {11'h0, flagZero});
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (4) @(posedge mclk);
		orLitZero();
		orFileBanked();
		orFileAccess();
		loadPointer();
		orFileIndexed();
		badPointer();
		resetAndFreeze();
		finalReport();
	end
	// Thirteen instructions and one reset need under 300 cycles; this leaves ample margin
	initial begin
		#(2000 * 8);
		fails++;
		finalReport();
	end
endmodule
`default_nettype wire
